// [rtl/battery_protector_fault_fsm.sv]
`timescale 1ns/1ps
// Summary of operation
// - Discharge overcurrent level chosen by 3-bit field, 14 to 83 mV, default 34.
// - Short-circuit bit picks 73 mV when clear, 148 mV when set.
// - Normal state closes both FETs and keeps checking every fault.
// - Firmware override can only open FETs, never close during a fault.
// - Charge and discharge overrides act independently; releasing is the only close.
// - Held overvoltage past delay enters overvoltage and arms charger-removal detect.
// - Overvoltage clears when pack 300 mV below cell and cell under release.
// - Held undervoltage enters undervoltage; without charger go to analog shutdown.
// - Undervoltage clears on charger attach with cell above release level.
// - Undervoltage reachable from low-voltage charging and from normal.
// - Held charge overcurrent trips; recovers when pack 300 mV below cell.
// - Held discharge overcurrent or short trips; recovers when pack within 300 mV.
// - Shutdown intent bit moves the protector into shutdown-wait.
// - Shutdown-wait opens FETs, returns on fault, else awaits charger removal.
// - Charger in analog shutdown: low-voltage charging below POR, else normal once no fault trips.
// - Low-voltage charging ties charge gate only above low-cell detect level.
// - Once per second, overheating while charging/discharging opens that FET.
// - Charging or discharging declared after current holds past quit time.
// - Overheat fault clears below the recovery limit of its own direction.
// - Sleeping wake comparator flags either-direction breach; low codes disable.
// - Coulomb integrator counts positive sense as charge, negative as discharge.
// - Overvoltage level from 3-bit field, 4.275 V stepping 25 mV, default 4.450.
// - Charge overcurrent level from 2-bit field, 6/13/18/28 mV, default 18.
module battery_protector_fault_fsm #(
  parameter int unsigned SECOND_TICKS = prot_pkg::SECOND_CYCLES,
  parameter int unsigned DELAY_W      = 16
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire prot_pkg::volt_meas_type volt_meas,
  input  wire logic signed [15:0]    sense_uv,
  input  wire logic signed [15:0]    current_ma,
  input  wire logic signed [15:0]    temperature,
  input  wire logic                  charger_present,
  input  wire logic                  sleeping,
  output logic                       chg_fet_on,
  output logic                       dsg_fet_on,
  output logic                       chg_gate_to_pack,
  output logic                       removal_detect_en,
  output logic                       regulator_on,
  output logic                       wake_event
);

  initial begin
    if (SECOND_TICKS < 2 || DELAY_W < 2 || DELAY_W > 31) $error("bad parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [11:0] config_q;
  logic [2:0]  control_q;
  logic [15:0] ovp_dly_q, uvp_dly_q, occ_dly_q, ocd_dly_q, scd_dly_q;
  logic signed [15:0] chg_cur_thr_q, dsg_cur_thr_q;
  logic [15:0] quit_time_q;
  logic signed [15:0] charge_heat_limit_q, discharge_heat_limit_q, charge_heat_limit_rec_q, discharge_heat_limit_rec_q;
  logic [7:0]  charge_heat_limit_time_q, discharge_heat_limit_time_q;
  logic signed [31:0] coulomb_q;
  prot_pkg::prot_state_type state_q, state_d;
  logic        charge_heat_limit_fault_q, discharge_heat_limit_fault_q, charging_q, discharging_q;

  wire apb_write = psel && penable && pwrite;
  wire apb_read  = psel && penable && !pwrite;

  function automatic logic known_addr(input logic [11:0] a);
    return a[1:0] == 2'h0 && a <= 12'h02c;
  endfunction

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !known_addr(paddr);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      config_q <= {prot_pkg::WAKE_SEL_RESET, prot_pkg::SCD_SEL_RESET, prot_pkg::OCD_SEL_RESET,
                   prot_pkg::OCC_SEL_RESET, prot_pkg::OVP_SEL_RESET};
      control_q     <= 3'h0;
      ovp_dly_q     <= 16'h0064;
      uvp_dly_q     <= 16'h0064;
      occ_dly_q     <= 16'h0064;
      ocd_dly_q     <= 16'h0064;
      scd_dly_q     <= 16'h000a;
      chg_cur_thr_q <= 16'sh0064;
      dsg_cur_thr_q <= -16'sh0064;
      quit_time_q   <= 16'h0064;
      charge_heat_limit_q      <= 16'sh01c2;
      discharge_heat_limit_q      <= 16'sh0226;
      charge_heat_limit_rec_q  <= 16'sh01a4;
      discharge_heat_limit_rec_q  <= 16'sh0208;
      charge_heat_limit_time_q <= 8'h02;
      discharge_heat_limit_time_q <= 8'h02;
    end else if (apb_write && pready && !pslverr) begin
      case (paddr)
        prot_pkg::OFF_CONFIG:  config_q  <= pwdata[11:0];
        prot_pkg::OFF_CONTROL: control_q <= pwdata[2:0];
        prot_pkg::OFF_OT_CFG: begin
          charge_heat_limit_time_q <= pwdata[7:0];
          discharge_heat_limit_time_q <= pwdata[15:8];
        end
        12'h014: begin
          charge_heat_limit_q <= pwdata[15:0];
          discharge_heat_limit_q <= pwdata[31:16];
        end
        12'h018: begin
          charge_heat_limit_rec_q <= pwdata[15:0];
          discharge_heat_limit_rec_q <= pwdata[31:16];
        end
        12'h01c: begin
          chg_cur_thr_q <= pwdata[15:0];
          dsg_cur_thr_q <= pwdata[31:16];
        end
        12'h020: begin
          ovp_dly_q <= pwdata[15:0];
          uvp_dly_q <= pwdata[31:16];
        end
        12'h024: begin
          occ_dly_q <= pwdata[15:0];
          ocd_dly_q <= pwdata[31:16];
        end
        12'h028: begin
          scd_dly_q   <= pwdata[15:0];
          quit_time_q <= pwdata[31:16];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        prot_pkg::OFF_CONFIG:  prdata <= {20'h00000, config_q};
        prot_pkg::OFF_CONTROL: prdata <= {29'h0, control_q};
        prot_pkg::OFF_STATUS:  prdata <= {24'h0, discharging_q, charging_q, discharge_heat_limit_fault_q,
                                          charge_heat_limit_fault_q, 1'b0, state_q};
        prot_pkg::OFF_COULOMB: prdata <= coulomb_q;
        prot_pkg::OFF_OT_CFG:  prdata <= {16'h0, discharge_heat_limit_time_q, charge_heat_limit_time_q};
        12'h014: prdata <= {discharge_heat_limit_q, charge_heat_limit_q};
        12'h018: prdata <= {discharge_heat_limit_rec_q, charge_heat_limit_rec_q};
        12'h01c: prdata <= {dsg_cur_thr_q, chg_cur_thr_q};
        12'h020: prdata <= {uvp_dly_q, ovp_dly_q};
        12'h024: prdata <= {ocd_dly_q, occ_dly_q};
        12'h028: prdata <= {quit_time_q, scd_dly_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thresholds
  wire [17:0] ocd_uv  = prot_pkg::OCD_TABLE_UV[config_q[prot_pkg::OCD_SEL_LSB +: 3]];
  wire [17:0] scd_uv  = config_q[prot_pkg::SCD_SEL_BIT] ? prot_pkg::SCD_HIGH_UV
                                                        : prot_pkg::SCD_LOW_UV;
  wire [15:0] occ_uv  = prot_pkg::OCC_TABLE_UV[config_q[prot_pkg::OCC_SEL_LSB +: 2]];
  wire [15:0] ovp_mv  = prot_pkg::OVP_BASE_MV +
                        16'(config_q[prot_pkg::OVP_SEL_LSB +: 3]) * prot_pkg::OVP_STEP_MV;
  wire [15:0] wake_uv = prot_pkg::WAKE_TABLE_UV[config_q[prot_pkg::WAKE_SEL_LSB +: 3]];

  // Two-stage synchronisers for async pins
  logic [1:0] chg_sync_q, sleep_sync_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chg_sync_q   <= 2'b00;
      sleep_sync_q <= 2'b00;
    end else begin
      chg_sync_q   <= {chg_sync_q[0], charger_present};
      sleep_sync_q <= {sleep_sync_q[0], sleeping};
    end
  end
  wire charger = chg_sync_q[1];

  function automatic logic [16:0] abs17(input logic signed [15:0] v);
    return v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
  endfunction

  wire [16:0] sense_mag = abs17(sense_uv);
  wire pack_low  = ({1'b0, volt_meas.pack_mv} + {1'b0, prot_pkg::PACK_DROP_MV}) <
                   {1'b0, volt_meas.cell_mv};
  wire cond_ovp  = volt_meas.cell_mv > ovp_mv;
  wire cond_uvp  = volt_meas.cell_mv < volt_meas.uv_trip_mv;
  wire cond_occ  = !sense_uv[15] && sense_mag > {1'b0, occ_uv};
  wire cond_ocd  = sense_uv[15] && {1'b0, sense_mag} > ocd_uv;
  wire cond_scd  = sense_uv[15] && {1'b0, sense_mag} > scd_uv;

  ////////////////////////////////////////////////////////////////////////////
  // Delay timers: restart whenever condition drops
  logic [4:0][15:0] dly_cnt_q;
  logic [4:0]       trip;
  wire  [4:0]       cond  = {cond_scd, cond_ocd, cond_occ, cond_uvp, cond_ovp};
  wire  [4:0][15:0] limit = {scd_dly_q, ocd_dly_q, occ_dly_q, uvp_dly_q, ovp_dly_q};

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_cnt_q <= '0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (!cond[i]) dly_cnt_q[i] <= 16'h0000;
        else if (dly_cnt_q[i] <= limit[i]) dly_cnt_q[i] <= dly_cnt_q[i] + 16'h0001;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 5; i++) trip[i] = cond[i] && dly_cnt_q[i] > limit[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protector state machine
  wire any_trip = |trip;

  always_comb begin
    state_d = state_q;
    case (state_q)
      prot_pkg::ST_NORMAL: begin
        if (trip[0])                 state_d = prot_pkg::ST_OVERVOLT;
        else if (trip[1])            state_d = prot_pkg::ST_UNDERVOLT;
        else if (trip[2])            state_d = prot_pkg::ST_OVERCUR_CHG;
        else if (trip[3] || trip[4]) state_d = prot_pkg::ST_OVERCUR_DSG;
        else if (control_q[prot_pkg::SHDN_BIT]) state_d = prot_pkg::ST_SHDN_WAIT;
      end
      prot_pkg::ST_OVERVOLT:
        if (pack_low && volt_meas.cell_mv < volt_meas.ov_release_mv) state_d = prot_pkg::ST_NORMAL;
      prot_pkg::ST_UNDERVOLT: begin
        if (charger && volt_meas.cell_mv > volt_meas.uv_release_mv) state_d = prot_pkg::ST_NORMAL;
        else if (!charger) state_d = prot_pkg::ST_ANALOG_OFF;
      end
      prot_pkg::ST_OVERCUR_CHG:
        if (pack_low) state_d = prot_pkg::ST_NORMAL;
      prot_pkg::ST_OVERCUR_DSG:
        if (!pack_low) state_d = prot_pkg::ST_NORMAL;
      prot_pkg::ST_SHDN_WAIT: begin
        if (any_trip)     state_d = prot_pkg::ST_NORMAL;
        else if (!charger) state_d = prot_pkg::ST_ANALOG_OFF;
      end
      prot_pkg::ST_ANALOG_OFF:
        if (charger) begin
          if (volt_meas.cell_mv < volt_meas.por_mv) state_d = prot_pkg::ST_LV_CHARGE;
          else if (!any_trip)                       state_d = prot_pkg::ST_NORMAL;
        end
      prot_pkg::ST_LV_CHARGE: begin
        // Trickle charge runs until POR; a cell still under the trip level then waits in undervoltage
        if (volt_meas.cell_mv >= volt_meas.por_mv)
          state_d = cond_uvp ? prot_pkg::ST_UNDERVOLT : prot_pkg::ST_NORMAL;
      end
      default: state_d = prot_pkg::ST_NORMAL;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) state_q <= prot_pkg::ST_NORMAL;
    else          state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Firmware overtemperature: one check per second
  logic [31:0] sec_cnt_q;
  logic [15:0] chg_hold_q, dsg_hold_q;
  logic [7:0]  charge_heat_limit_cnt_q, discharge_heat_limit_cnt_q;
  wire sec_tick = sec_cnt_q == SECOND_TICKS - 1;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) sec_cnt_q <= 32'h0;
    else          sec_cnt_q <= sec_tick ? 32'h0 : sec_cnt_q + 32'h1;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chg_hold_q    <= 16'h0;
      dsg_hold_q    <= 16'h0;
      charging_q    <= 1'b0;
      discharging_q <= 1'b0;
    end else if (sec_tick) begin
      chg_hold_q    <= current_ma > chg_cur_thr_q ? chg_hold_q + 16'h1 : 16'h0;
      dsg_hold_q    <= current_ma < dsg_cur_thr_q ? dsg_hold_q + 16'h1 : 16'h0;
      charging_q    <= current_ma > chg_cur_thr_q && chg_hold_q + 16'h1 >= quit_time_q;
      discharging_q <= current_ma < dsg_cur_thr_q && dsg_hold_q + 16'h1 >= quit_time_q;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      charge_heat_limit_cnt_q   <= 8'h0;
      discharge_heat_limit_cnt_q   <= 8'h0;
      charge_heat_limit_fault_q <= 1'b0;
      discharge_heat_limit_fault_q <= 1'b0;
    end else if (sec_tick) begin
      charge_heat_limit_cnt_q <= (charging_q && temperature > charge_heat_limit_q) ? charge_heat_limit_cnt_q + 8'h1 : 8'h0;
      discharge_heat_limit_cnt_q <= (discharging_q && temperature > discharge_heat_limit_q) ? discharge_heat_limit_cnt_q + 8'h1 : 8'h0;
      if (charging_q && temperature > charge_heat_limit_q && charge_heat_limit_cnt_q + 8'h1 >= charge_heat_limit_time_q)
        charge_heat_limit_fault_q <= 1'b1;
      else if (temperature < charge_heat_limit_rec_q) charge_heat_limit_fault_q <= 1'b0;
      if (discharging_q && temperature > discharge_heat_limit_q && discharge_heat_limit_cnt_q + 8'h1 >= discharge_heat_limit_time_q)
        discharge_heat_limit_fault_q <= 1'b1;
      else if (temperature < discharge_heat_limit_rec_q) discharge_heat_limit_fault_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FET drive, coulomb counter, wake comparator
  wire hw_chg = state_d == prot_pkg::ST_NORMAL || state_d == prot_pkg::ST_OVERCUR_DSG;
  wire hw_dsg = state_d == prot_pkg::ST_NORMAL || state_d == prot_pkg::ST_OVERVOLT ||
                state_d == prot_pkg::ST_OVERCUR_CHG;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chg_fet_on        <= 1'b0;
      dsg_fet_on        <= 1'b0;
      chg_gate_to_pack  <= 1'b0;
      removal_detect_en <= 1'b0;
      regulator_on      <= 1'b1;
    end else begin
      // Override can only remove drive; hardware state gates it first
      chg_fet_on <= hw_chg && !control_q[prot_pkg::CHG_OVR_BIT] && !charge_heat_limit_fault_q;
      dsg_fet_on <= hw_dsg && !control_q[prot_pkg::DSG_OVR_BIT] && !discharge_heat_limit_fault_q;
      chg_gate_to_pack  <= state_d == prot_pkg::ST_LV_CHARGE &&
                           volt_meas.cell_mv > volt_meas.lv_detect_mv;
      removal_detect_en <= state_d == prot_pkg::ST_OVERVOLT;
      regulator_on      <= state_d != prot_pkg::ST_ANALOG_OFF;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) coulomb_q <= 32'sh0;
    else          coulomb_q <= coulomb_q + 32'(sense_uv);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) wake_event <= 1'b0;
    else wake_event <= sleep_sync_q[1] && wake_uv != 16'h0 && sense_mag > {1'b0, wake_uv};
  end

endmodule

// [rtl/prot_pkg.sv]
package prot_pkg;

  // Register byte offsets
  localparam logic [11:0] OFF_CONFIG  = 12'h000;
  localparam logic [11:0] OFF_CONTROL = 12'h004;
  localparam logic [11:0] OFF_STATUS  = 12'h008;
  localparam logic [11:0] OFF_COULOMB = 12'h00c;
  localparam logic [11:0] OFF_OT_CFG  = 12'h010;

  // Config fields
  localparam int OVP_SEL_LSB  = 0;
  localparam int OCC_SEL_LSB  = 3;
  localparam int OCD_SEL_LSB  = 5;
  localparam int SCD_SEL_BIT  = 8;
  localparam int WAKE_SEL_LSB = 9;
  localparam logic [2:0] OVP_SEL_RESET  = 3'h7;
  localparam logic [1:0] OCC_SEL_RESET  = 2'h2;
  localparam logic [2:0] OCD_SEL_RESET  = 3'h2;
  localparam logic       SCD_SEL_RESET  = 1'b0;
  localparam logic [2:0] WAKE_SEL_RESET = 3'h0;

  // Control fields
  localparam int CHG_OVR_BIT  = 0;
  localparam int DSG_OVR_BIT  = 1;
  localparam int SHDN_BIT     = 2;

  // Trip tables in microvolts / millivolts
  // Discharge levels pass 65 mV, so these need 18 bits
  localparam logic [17:0] OCD_TABLE_UV [8] = '{18'd14000, 18'd24000, 18'd34000, 18'd44000,
                                              18'd53000, 18'd63000, 18'd73000, 18'd83000};
  localparam logic [15:0] OCC_TABLE_UV [4] = '{16'd6000, 16'd13000, 16'd18000, 16'd28000};
  localparam logic [17:0] SCD_LOW_UV  = 18'd73000;
  localparam logic [17:0] SCD_HIGH_UV = 18'd148000;
  localparam logic [15:0] OVP_BASE_MV = 16'd4275;
  localparam logic [15:0] OVP_STEP_MV = 16'd25;
  localparam logic [15:0] WAKE_TABLE_UV [8] = '{16'd0, 16'd0, 16'd1000, 16'd2200,
                                               16'd2200, 16'd4600, 16'd4600, 16'd9800};
  localparam logic [15:0] PACK_DROP_MV = 16'd300;

  // Timing counts (cycles, 100 MHz)
  localparam int CLK_MHZ        = 100;
  localparam int SECOND_US      = 1000000;
  localparam int SECOND_CYCLES  = SECOND_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_NORMAL, ST_OVERVOLT, ST_UNDERVOLT, ST_OVERCUR_CHG, ST_OVERCUR_DSG,
    ST_SHDN_WAIT, ST_ANALOG_OFF, ST_LV_CHARGE
  } prot_state_type;

  typedef struct packed {
    logic [15:0] cell_mv;
    logic [15:0] pack_mv;
    logic [15:0] lv_detect_mv;
    logic [15:0] ov_release_mv;
    logic [15:0] uv_trip_mv;
    logic [15:0] uv_release_mv;
    logic [15:0] por_mv;
  } volt_meas_type;

endpackage

// [tb/battery_protector_fault_fsm_assertions.sv]
`timescale 1ns/1ps
module prot_checker (
  input wire logic                    sys_clk,
  input wire logic                    reset_n,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire prot_pkg::volt_meas_type volt_meas,
  input wire logic                    sleeping,
  input wire logic                    chg_fet_on,
  input wire logic                    dsg_fet_on,
  input wire logic                    chg_gate_to_pack,
  input wire logic                    removal_detect_en,
  input wire logic                    wake_event
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic ctl_wr;
  assign ctl_wr = psel && penable && pready && pwrite && paddr == 12'h004;
  ready_follow_a: assert property (psel && !penable |=> pready) else $error("pready late");
  ready_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  slverr_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  unmapped_err_a: assert property (psel && penable && pready && (paddr > 12'h02c || paddr[1:0] != 2'h0)
    |-> pslverr) else $error("unmapped access not refused");
  chg_open_a: assert property (ctl_wr && pwdata[0] |-> ##[1:2] !chg_fet_on) else $error("chg not opened");
  dsg_open_a: assert property (ctl_wr && pwdata[1] |-> ##[1:2] !dsg_fet_on) else $error("dsg not opened");
  wake_quiet_a: assert property (!sleeping [*5] |-> !wake_event) else $error("wake while awake");
  lv_gate_a: assert property (chg_gate_to_pack |-> $past(volt_meas.cell_mv) > $past(volt_meas.lv_detect_mv))
    else $error("gate tied below detect level");
  cover property (pslverr);
  cover property (removal_detect_en);
  cover property (wake_event);
  cover property (chg_gate_to_pack);
endmodule
bind battery_protector_fault_fsm prot_checker i_prot_checker (.sys_clk, .reset_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .volt_meas, .sleeping, .chg_fet_on, .dsg_fet_on, .chg_gate_to_pack,
  .removal_detect_en, .wake_event);

// [tb/battery_protector_fault_fsm_bench.sv]
`timescale 1ns/1ps
module battery_protector_fault_fsm_bench;
  logic                    sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, err, sleeping;
  logic                    chg_fet_on, dsg_fet_on, chg_gate_to_pack, removal_detect_en, regulator_on;
  logic                    wake_event, charger_on, charger_present;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, rd, ca;
  logic [15:0]             cell_mv;
  logic signed [15:0]      isense, sense_uv, pack_ofs;
  prot_pkg::volt_meas_type volt_meas;
  int                      errors, n_compared, i;

  battery_protector_fault_fsm #(.SECOND_TICKS(20)) i_battery_protector_fault_fsm (.sys_clk(sys_clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .volt_meas(volt_meas), .sense_uv(sense_uv),
    .current_ma(16'sh0000), .temperature(16'sh0bb8), .charger_present(charger_present), .sleeping(sleeping),
    .chg_fet_on(chg_fet_on), .dsg_fet_on(dsg_fet_on), .chg_gate_to_pack(chg_gate_to_pack),
    .removal_detect_en(removal_detect_en), .regulator_on(regulator_on), .wake_event(wake_event));
  cell_charger_model i_cell_charger_model (.cell_mv(cell_mv), .pack_ofs(pack_ofs), .isense(isense),
    .charger_on(charger_on), .chg_fet_on(chg_fet_on), .dsg_fet_on(dsg_fet_on), .volt_meas(volt_meas),
    .sense_uv(sense_uv), .charger_present(charger_present));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wait_st(input prot_pkg::prot_state_type s);
    int k;
    for (k = 0; k < 60; k++) begin
      apb(1'b0, prot_pkg::OFF_STATUS, 32'h0);
      if (rd[2:0] === s) break;
    end
    check({29'h0, rd[2:0]}, {29'h0, s});
  endtask

  task automatic final_report;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Whole sequence needs well under 20k cycles
  initial begin
    repeat (50000) @(posedge sys_clk);
    errors++;
    final_report;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    cell_mv = 16'h0e74; pack_ofs = 16'sh0000; isense = 16'sh0000; charger_on = 1'b0; sleeping = 1'b0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(negedge sys_clk);
    check({chg_fet_on, dsg_fet_on, regulator_on}, 3'h7);
    apb(1'b0, prot_pkg::OFF_CONFIG, 32'h0);
    check(rd, 32'h00000057);
    apb(1'b0, 12'h100, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    apb(1'b1, 12'h020, 32'h00040004);
    apb(1'b1, 12'h024, 32'h00040004);
    apb(1'b1, 12'h028, 32'h00010004);
    for (i = 1; i < 5; i++) begin
      apb(1'b1, prot_pkg::OFF_CONTROL, i % 4);
      repeat (3) @(negedge sys_clk);
      check({chg_fet_on, dsg_fet_on}, {~i[0], ~i[1]});
    end
    // Lowest trip codes keep the currents inside the sense range
    apb(1'b1, prot_pkg::OFF_CONFIG, 32'h00000400);
    repeat (2) begin
      cell_mv <= 16'h10cc;
      repeat (3) @(posedge sys_clk);
      cell_mv <= 16'h0e74;
      @(posedge sys_clk);
    end
    wait_st(prot_pkg::ST_NORMAL);
    cell_mv <= 16'h10cc;
    wait_st(prot_pkg::ST_OVERVOLT);
    check(removal_detect_en, 1'b1);
    pack_ofs <= -16'sd400;
    repeat (10) @(posedge sys_clk);
    wait_st(prot_pkg::ST_OVERVOLT);
    cell_mv <= 16'h0fd2;
    wait_st(prot_pkg::ST_NORMAL);
    pack_ofs <= 16'sh0000;
    isense <= 16'sd7000;
    wait_st(prot_pkg::ST_OVERCUR_CHG);
    check(chg_fet_on, 1'b0);
    // Charger removed: current stops and the pack falls below the cell
    isense <= 16'sh0000;
    pack_ofs <= -16'sd400;
    wait_st(prot_pkg::ST_NORMAL);
    // Heavy load pulls the pack down until it is removed
    isense <= -16'sd15000;
    wait_st(prot_pkg::ST_OVERCUR_DSG);
    check(dsg_fet_on, 1'b0);
    isense <= 16'sh0000;
    pack_ofs <= 16'sh0000;
    wait_st(prot_pkg::ST_NORMAL);
    sleeping <= 1'b1;
    isense <= -16'sd1500;
    repeat (6) @(negedge sys_clk);
    check(wake_event, 1'b1);
    isense <= 16'sd1500;
    repeat (6) @(negedge sys_clk);
    check(wake_event, 1'b1);
    apb(1'b1, prot_pkg::OFF_CONFIG, 32'h0);
    repeat (6) @(negedge sys_clk);
    check(wake_event, 1'b0);
    sleeping <= 1'b0;
    isense <= 16'sd2000;
    apb(1'b0, prot_pkg::OFF_COULOMB, 32'h0);
    ca = rd;
    apb(1'b0, prot_pkg::OFF_COULOMB, 32'h0);
    check($signed(rd - ca) > 0, 1'b1);
    isense <= -16'sd2000;
    apb(1'b0, prot_pkg::OFF_COULOMB, 32'h0);
    ca = rd;
    apb(1'b0, prot_pkg::OFF_COULOMB, 32'h0);
    check($signed(rd - ca) < 0, 1'b1);
    isense <= 16'sh0000;
    charger_on <= 1'b1;
    apb(1'b1, prot_pkg::OFF_CONTROL, 32'h4);
    wait_st(prot_pkg::ST_SHDN_WAIT);
    check({chg_fet_on, dsg_fet_on}, 2'h0);
    charger_on <= 1'b0;
    wait_st(prot_pkg::ST_ANALOG_OFF);
    check(regulator_on, 1'b0);
    apb(1'b1, prot_pkg::OFF_CONTROL, 32'h0);
    charger_on <= 1'b1;
    wait_st(prot_pkg::ST_NORMAL);
    cell_mv <= 16'h0a8c;
    wait_st(prot_pkg::ST_UNDERVOLT);
    cell_mv <= 16'h0c1c;
    wait_st(prot_pkg::ST_NORMAL);
    charger_on <= 1'b0;
    cell_mv <= 16'h07d0;
    wait_st(prot_pkg::ST_ANALOG_OFF);
    charger_on <= 1'b1;
    wait_st(prot_pkg::ST_LV_CHARGE);
    check(chg_gate_to_pack, 1'b1);
    cell_mv <= 16'h06a4;
    repeat (5) @(negedge sys_clk);
    check(chg_gate_to_pack, 1'b0);
    final_report;
  end
endmodule

// [tb/cell_charger_model.sv]
`timescale 1ns/1ps
module cell_charger_model #(
  parameter logic [15:0] LV_DET  = 16'h0708,
  parameter logic [15:0] OV_REL  = 16'h1004,
  parameter logic [15:0] UV_TRIP = 16'h0af0,
  parameter logic [15:0] UV_REL  = 16'h0bb8,
  parameter logic [15:0] POR     = 16'h0898
) (
  input  wire logic [15:0]           cell_mv,
  input  wire logic signed [15:0]    pack_ofs,
  input  wire logic signed [15:0]    isense,
  input  wire logic                  charger_on,
  input  wire logic                  chg_fet_on,
  input  wire logic                  dsg_fet_on,
  output prot_pkg::volt_meas_type    volt_meas,
  output logic signed [15:0]         sense_uv,
  output logic                       charger_present
);
  logic [15:0] pack_mv;
  // Attached charger lifts the pack above the cell
  assign pack_mv = charger_on ? cell_mv + 16'h00c8 : cell_mv + pack_ofs;
  assign charger_present = charger_on;
  assign volt_meas = '{cell_mv, pack_mv, LV_DET, OV_REL, UV_TRIP, UV_REL, POR};
  // Open charge FET blocks positive current; open discharge FET blocks negative
  assign sense_uv = (isense > 0 && !chg_fet_on) || (isense < 0 && !dsg_fet_on) ? 16'sh0000 : isense;
endmodule
